/* File: verilog/lfd_cmd_top.sv */
// Command interpreter and control/status logic of the antenna driver.
`timescale 1ns/10ps
`default_nettype none
module lfd_cmd_top
  import lfd_pkg::*;
#(
  parameter int unsigned TX_BIT_CYCLES = TX_BIT_NS / CLK_NS // Cycles per sent bit.
)
(
  input  wire logic        MCLK,           // System clock, 125 MHz.
  input  wire logic        RST_N,          // Synchronous reset, active low.
  input  wire logic        SCLK,           // Serial clock from the host.
  input  wire logic        SDI,            // Serial data from the host.
  input  wire logic        CHIP_SELECT_N,  // Frame select, active low.
  output logic             SDO,            // Serial data to the host.
  output logic             SDO_OE,         // High while SDO is driven.
  input  wire logic        PREWARN_IN,     // Temperature pre-warning event.
  input  wire logic        OVERTEMP_IN,    // Over-temperature event.
  input  wire logic        VD_LOW_IN,      // Logic supply undervoltage event.
  input  wire logic        VS_LOW_IN,      // Main supply undervoltage event.
  input  wire logic [7:0]  OVERCURRENT_IN, // Overcurrent event per output.
  input  wire logic        MEAS_A_VALID,   // New first current value.
  input  wire logic [4:0]  MEAS_A_VALUE,   // First measured current.
  input  wire logic        MEAS_B_VALID,   // New second current value.
  input  wire logic [4:0]  MEAS_B_VALUE,   // Second measured current.
  output logic             TX_BIT,         // Bit driven to the antenna stage.
  output logic             TX_ACTIVE,      // High while a buffer is sent.
  output logic             OUTPUTS_TRISTATE, // High while asleep.
  output logic [55:0]      CONFIG_WORD,    // Configuration register.
  output logic [27:0]      MEAS_SETUP,     // Measurement triggers and timers.
  output logic             MEAS_REARM      // Pulse after a setup write.
);
  logic        frame_start;    // Frame begins.
  logic        frame_done;     // Complete frame received.
  logic [63:0] rx_word;        // Received frame.
  logic [63:0] load_word;      // Frame to send next.
  logic [2:0]  cmd_code;       // Command code of the finished frame.
  logic        cmd_msb;        // Readback selector of the finished frame.
  logic [55:0] payload;        // Data part of the finished frame.
  logic [55:0] cfg;            // Configuration register.
  logic [55:0] data1;          // Transmit buffer 1.
  logic [55:0] data2;          // Transmit buffer 2.
  logic [27:0] meas;           // Measurement setup field.
  logic [4:0]  flags;          // Pre-warn, overtemp, VD low, VS low, failure.
  logic [4:0]  flag_event;     // Events that set the flags.
  logic [4:0]  flag_seen;      // Flags shown in the current readback.
  logic [7:0]  oc_flags;       // Overcurrent per output.
  logic [7:0]  oc_seen;        // Overcurrent bits shown in the readback.
  logic [4:0]  cur_a;          // First measured current.
  logic [4:0]  cur_b;          // Second measured current.
  logic [7:0]  prev_cmd;       // Command byte of the previous frame.
  logic [1:0]  mode;           // Transmit mode code.
  logic [55:0] stat_word;      // Assembled control/status word.
  logic        read_clear;     // Readback of status completed.
  logic        start_req;      // Request to begin sending.
  logic        tx_end_bit;     // Last bit of a buffer is done.
  logic [15:0] div_cnt;        // Bit time divider.
  logic        bit_en;         // One-cycle pulse per sent bit.
  logic [5:0]  bit_idx;        // Bit index inside a buffer.
  logic [55:0] tx_sh;          // Outgoing antenna data.
  lfd_resp_t     resp_sel;     // Register for the next readback.
  lfd_resp_t     resp_now;     // Register being returned now.
  lfd_tx_state_t tx_state;     // Transmit engine state.

  // Serial shifter; its select framing discards incomplete frames.
  lfd_spi_shift u_shift (
    .mclk          (MCLK),
    .rst_n         (RST_N),
    .sclk          (SCLK),
    .sdi           (SDI),
    .chip_select_n (CHIP_SELECT_N),
    .sdo           (SDO),
    .sdo_oe        (SDO_OE),
    .load_word     (load_word),
    .frame_start   (frame_start),
    .frame_done    (frame_done),
    .rx_word       (rx_word)
  );

  // The low three bits pick the command, the MSB picks the readback after a no-command frame.
  assign cmd_code = rx_word[NIB_LO_LSB+2:NIB_LO_LSB];
  assign cmd_msb  = rx_word[NIB_MSB];
  assign payload  = rx_word[DATA_BITS-1:0];

  // Transmit mode: sleep or idle both report ready.
  always_comb
  begin
    case (tx_state)
      TX_SEND1: mode = MODE_DATA1;
      TX_SEND2: mode = MODE_DATA2;
      default:  mode = MODE_READY;
    endcase
  end

  // Status word; the two unused bits are constant zero.
  assign stat_word = {meas, ST_UNUSED, mode, cfg[CFG_SLEEP_BIT], flags[4:1],
                      flags[0], oc_flags, cur_a, cur_b};

  // Response for the frame about to start: echoed command and a register.
  always_comb
  begin
    case (resp_sel)
      RESP_CONFIG: load_word = {prev_cmd, cfg};
      RESP_DATA1:  load_word = {prev_cmd, data1};
      RESP_DATA2:  load_word = {prev_cmd, data2};
      RESP_STATUS: load_word = {prev_cmd, stat_word};
      default:     load_word = {prev_cmd, cfg};
    endcase
  end

  // Readback choice for the next frame, decided as each frame ends.
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      resp_sel <= RESP_CONFIG;
      prev_cmd <= '0;
    end
    else if (frame_done)
    begin
      prev_cmd <= rx_word[CMD_MSB:CMD_LSB];
      case (cmd_code)
        CMD_CONFIG: resp_sel <= RESP_CONFIG;
        CMD_DATA1:  resp_sel <= RESP_DATA1;
        CMD_DATA2:  resp_sel <= RESP_DATA2;
        CMD_MEAS:   resp_sel <= RESP_STATUS;
        CMD_START:  resp_sel <= RESP_STATUS;
        // No command: the MSB chooses status or configuration.
        default:    resp_sel <= cmd_msb ? RESP_STATUS : RESP_CONFIG;
      endcase
    end
  end

  // Remember which register the running frame returns and which flags it
  // showed, so only those flags are cleared when the read completes.
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      resp_now  <= RESP_CONFIG;
      flag_seen <= '0;
      oc_seen   <= '0;
    end
    else if (frame_start)
    begin
      resp_now  <= resp_sel;
      flag_seen <= (resp_sel == RESP_STATUS) ? flags : 5'h00;
      oc_seen   <= (resp_sel == RESP_STATUS) ? oc_flags : 8'h00;
    end
  end

  assign read_clear = frame_done && (resp_now == RESP_STATUS);

  // Configuration register, holding sleep and send mode.
  // Power-on leaves the device asleep; waking keeps every register.
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      cfg <= CFG_RESET;
    end
    else if (frame_done && cmd_code == CMD_CONFIG)
    begin
      cfg <= payload;
    end
  end

  // Transmit buffers; a no-command frame touches neither.
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      data1 <= '0;
      data2 <= '0;
    end
    else if (frame_done)
    begin
      if (cmd_code == CMD_DATA1)
      begin
        data1 <= payload;
      end
      if (cmd_code == CMD_DATA2)
      begin
        data2 <= payload;
      end
    end
  end

  // Measurement setup; may be rewritten for each new measurement.
  // Reset gives meas2 output select = 1 and both timers = 1.
  // Only the top 28 bits of the payload are kept; status bits are read-only.
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      meas       <= MEAS_RESET;
      MEAS_REARM <= 1'b0;
    end
    else
    begin
      MEAS_REARM <= frame_done && (cmd_code == CMD_MEAS);
      if (frame_done && cmd_code == CMD_MEAS)
      begin
        meas <= payload[DATA_BITS-1:DATA_BITS-MEAS_BITS];
      end
    end
  end

  // Failure summary follows overtemp, main undervoltage and any overcurrent.
  assign flag_event = {PREWARN_IN, OVERTEMP_IN, VD_LOW_IN, VS_LOW_IN,
                       OVERTEMP_IN | VS_LOW_IN | (|OVERCURRENT_IN)};

  // Sticky fault flags cleared by a completed status read. A new event in
  // the clearing cycle wins, so no fault is lost.
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      flags    <= '0;
      oc_flags <= '0;
    end
    else
    begin
      flags    <= (flags & ~(read_clear ? flag_seen : 5'h00)) | flag_event;
      oc_flags <= (oc_flags & ~(read_clear ? oc_seen : 8'h00)) | OVERCURRENT_IN;
    end
  end

  // Measured currents hold until a fresh measurement arrives.
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      cur_a <= '0;
      cur_b <= '0;
    end
    else
    begin
      if (MEAS_A_VALID)
      begin
        cur_a <= MEAS_A_VALUE;
      end
      if (MEAS_B_VALID)
      begin
        cur_b <= MEAS_B_VALUE;
      end
    end
  end

  // Start on command, or at once when send mode is set and buffer1 has
  // just been filled. The host keeps the wake-to-start spacing.
  always_comb
  begin
    start_req = 1'b0;
    if (frame_done && !cfg[CFG_SLEEP_BIT] && tx_state == TX_IDLE)
    begin
      if (cmd_code == CMD_START)
      begin
        start_req = 1'b1;
      end
      else if (cmd_code == CMD_DATA1 && cfg[CFG_SEND_BIT])
      begin
        start_req = 1'b1;
      end
    end
  end

  // Bit time divider; runs only while sending so the first bit is full.
  always_ff @(posedge MCLK)
  begin
    if (!RST_N || tx_state == TX_IDLE)
    begin
      div_cnt <= '0;
      bit_en  <= 1'b0;
    end
    else if (div_cnt == 16'(TX_BIT_CYCLES - 1))
    begin
      div_cnt <= '0;
      bit_en  <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + 16'h0001;
      bit_en  <= 1'b0;
    end
  end

  assign tx_end_bit = bit_en && (bit_idx == DATA_LAST);

  // Transmit engine: buffer1 then buffer2, each MSB first. Sleep aborts
  // a transfer since the outputs go high impedance anyway.
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      tx_state <= TX_IDLE;
      tx_sh    <= '0;
      bit_idx  <= '0;
    end
    else if (cfg[CFG_SLEEP_BIT])
    begin
      tx_state <= TX_IDLE;
      bit_idx  <= '0;
    end
    else
    begin
      case (tx_state)
        TX_IDLE:
        begin
          if (start_req)
          begin
            // With auto-send the just-received word goes out directly.
            tx_sh    <= (cmd_code == CMD_DATA1) ? payload : data1;
            bit_idx  <= '0;
            tx_state <= TX_SEND1;
          end
        end
        TX_SEND1, TX_SEND2:
        begin
          if (tx_end_bit)
          begin
            bit_idx  <= '0;
            tx_sh    <= data2;
            tx_state <= (tx_state == TX_SEND1) ? TX_SEND2 : TX_IDLE;
          end
          else if (bit_en)
          begin
            tx_sh   <= {tx_sh[54:0], 1'b0};
            bit_idx <= bit_idx + 6'h01;
          end
        end
        default:
        begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // Output drive: most significant bit first, nothing while idle.
  assign TX_BIT           = tx_sh[DATA_BITS-1] & TX_ACTIVE;
  assign TX_ACTIVE        = (tx_state != TX_IDLE);
  assign OUTPUTS_TRISTATE = cfg[CFG_SLEEP_BIT];
  assign CONFIG_WORD      = cfg;
  assign MEAS_SETUP       = meas;
endmodule
`default_nettype wire

/* File: verilog/lfd_pkg.sv */
// Shared constants and types of the antenna driver command interpreter.
package lfd_pkg;
  // Frame shape: one command byte followed by 56 data bits.
  localparam int unsigned FRAME_BITS = 64;
  localparam int unsigned DATA_BITS  = 56;
  localparam logic [6:0]  FRAME_LEN  = 7'h40;
  localparam logic [5:0]  DATA_LAST  = 6'h37;
  // Command codes in the low three bits of the command nibble.
  localparam logic [2:0]  CMD_NONE   = 3'h0;
  localparam logic [2:0]  CMD_CONFIG = 3'h1;
  localparam logic [2:0]  CMD_MEAS   = 3'h2;
  localparam logic [2:0]  CMD_DATA1  = 3'h3;
  localparam logic [2:0]  CMD_DATA2  = 3'h4;
  localparam logic [2:0]  CMD_START  = 3'h5;
  // Field positions in the received frame.
  localparam int unsigned CMD_MSB    = 63;
  localparam int unsigned CMD_LSB    = 56;
  localparam int unsigned NIB_MSB    = 63;
  localparam int unsigned NIB_LO_LSB = 60;
  // Configuration register bits and reset value.
  localparam int unsigned CFG_SLEEP_BIT = 0;
  localparam int unsigned CFG_SEND_BIT  = 1;
  localparam logic [55:0] CFG_RESET     = 56'h00_0000_0000_0003;
  // Writable measurement setup field, top 28 bits of the status word.
  localparam int unsigned MEAS_BITS     = 28;
  localparam logic [27:0] MEAS_RESET    = 28'h0080201;
  // Status field positions inside the 56-bit status word.
  localparam int unsigned ST_MODE_LSB   = 24;
  localparam int unsigned ST_SLEEP      = 23;
  localparam int unsigned ST_PREWARN    = 22;
  localparam int unsigned ST_OVERTEMP   = 21;
  localparam int unsigned ST_VD_LOW     = 20;
  localparam int unsigned ST_VS_LOW     = 19;
  localparam int unsigned ST_FAIL       = 18;
  localparam int unsigned ST_OC_LSB     = 10;
  localparam int unsigned ST_CURA_LSB   = 5;
  localparam int unsigned ST_CURB_LSB   = 0;
  localparam logic [1:0]  ST_UNUSED     = 2'h0;
  // Transmit mode codes.
  localparam logic [1:0]  MODE_READY    = 2'h0;
  localparam logic [1:0]  MODE_DATA1    = 2'h2;
  localparam logic [1:0]  MODE_DATA2    = 2'h3;
  // Transmit bit time and clock period.
  localparam int unsigned CLK_NS        = 8;
  localparam int unsigned TX_BIT_NS     = 256000;
  // Register returned on the serial output in the next frame.
  typedef enum logic [1:0] {RESP_CONFIG, RESP_DATA1, RESP_DATA2, RESP_STATUS} lfd_resp_t;
  // Transmit engine states.
  typedef enum logic [1:0] {TX_IDLE, TX_SEND1, TX_SEND2} lfd_tx_state_t;
endpackage

/* File: verilog/lfd_spi_shift.sv */
// Serial frame shifter: samples the serial pins and moves 64-bit frames.
`timescale 1ns/10ps
`default_nettype none
module lfd_spi_shift
  import lfd_pkg::*;
(
  input  wire logic        mclk,          // System clock.
  input  wire logic        rst_n,         // Synchronous reset, active low.
  input  wire logic        sclk,          // Serial clock, sampled.
  input  wire logic        sdi,           // Serial data in.
  input  wire logic        chip_select_n, // Frame select, active low.
  output logic             sdo,           // Serial data out.
  output logic             sdo_oe,        // Serial output enable.
  input  wire logic [63:0] load_word,     // Word to send, taken at frame start.
  output logic             frame_start,   // Pulse at select falling edge.
  output logic             frame_done,    // Pulse when a full frame ends.
  output logic [63:0]      rx_word        // Received frame.
);
  logic       sclk_d;   // Previous serial clock sample.
  logic       cs_d;     // Previous select sample.
  logic [6:0] bit_cnt;  // Bits received, saturating.
  logic [63:0] tx_sh;   // Outgoing shift register.
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_rise;

  assign frame_start = cs_d & ~chip_select_n;
  assign cs_rise     = ~cs_d & chip_select_n;
  assign sclk_rise   = ~sclk_d & sclk & ~chip_select_n;
  assign sclk_fall   = sclk_d & ~sclk & ~chip_select_n;
  // A frame counts only with exactly 64 clocks; anything else is dropped.
  assign frame_done  = cs_rise && (bit_cnt == FRAME_LEN);
  assign sdo         = tx_sh[FRAME_BITS-1];
  assign sdo_oe      = ~chip_select_n;

  // Edge history of the pins.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sclk_d <= 1'b0;
      cs_d   <= 1'b1;
    end
    else
    begin
      sclk_d <= sclk;
      cs_d   <= chip_select_n;
    end
  end

  // Receive path: command bits arrive first, MSB first.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rx_word <= '0; // Shift register cleared at power-on.
      bit_cnt <= '0;
    end
    else if (frame_start)
    begin
      bit_cnt <= '0;
    end
    else if (sclk_rise)
    begin
      rx_word <= {rx_word[62:0], sdi};
      // Saturate one past a full frame so long frames are rejected too.
      if (bit_cnt != FRAME_LEN + 7'h01)
      begin
        bit_cnt <= bit_cnt + 7'h01;
      end
    end
  end

  // Transmit path: new bit after each falling clock edge.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      tx_sh <= '0;
    end
    else if (frame_start)
    begin
      tx_sh <= load_word;
    end
    else if (sclk_fall)
    begin
      tx_sh <= {tx_sh[62:0], 1'b0};
    end
  end
endmodule
`default_nettype wire

/* File: verif/lfd_cmd_properties.sv */
// Port-level assertions for the command interpreter top.
`timescale 1ns/10ps
`default_nettype none
module lfd_cmd_properties
  import lfd_pkg::*;
#(
  parameter int unsigned TX_BIT_CYCLES = 4 // Cycles per sent bit.
)
(
  input wire logic        MCLK,             // System clock.
  input wire logic        RST_N,            // Synchronous reset, active low.
  input wire logic        CHIP_SELECT_N,    // Frame select, active low.
  input wire logic        SDO_OE,           // Serial output enable.
  input wire logic        TX_BIT,           // Antenna data bit.
  input wire logic        TX_ACTIVE,        // Transmission running.
  input wire logic        OUTPUTS_TRISTATE, // Outputs off while asleep.
  input wire logic [55:0] CONFIG_WORD,      // Configuration register.
  input wire logic [27:0] MEAS_SETUP,       // Measurement setup register.
  input wire logic        MEAS_REARM        // Pulse after a setup write.
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  int unsigned act_cnt; // Cycles of the running transmission.
  // Counts active cycles; a sleep abort cuts the count short, so that case is exempt.
  always_ff @(posedge MCLK)
  begin
    act_cnt <= TX_ACTIVE ? act_cnt + 32'h1 : 32'h0;
  end
  // Three asleep cycles give a sleep abort time to land.
  sequence s_asleep;
    OUTPUTS_TRISTATE [*3];
  endsequence
  // The setup pulse lasts exactly one cycle.
  sequence s_rearm_pulse;
    MEAS_REARM ##1 !MEAS_REARM;
  endsequence
  chk_oe_follows_cs: assert property (SDO_OE == !CHIP_SELECT_N)
    else $error("SDO_OE does not follow chip select");
  chk_reset_state: assert property ($rose(RST_N) |-> CONFIG_WORD == CFG_RESET
    && MEAS_SETUP == MEAS_RESET && OUTPUTS_TRISTATE && !TX_ACTIVE && !MEAS_REARM)
    else $error("wrong state after reset");
  chk_sleep_output: assert property (OUTPUTS_TRISTATE == CONFIG_WORD[CFG_SLEEP_BIT])
    else $error("tristate differs from sleep bit");
  chk_rearm_single: assert property (MEAS_REARM |-> s_rearm_pulse)
    else $error("setup pulse longer than one cycle");
  chk_setup_rearm: assert property ($changed(MEAS_SETUP) |-> MEAS_REARM)
    else $error("setup changed without pulse");
  // A write lands on the edge that sees select high after it was low, so
  // the change shows one cycle after that select rise and never elsewhere.
  chk_config_frame: assert property ($changed(CONFIG_WORD) |->
    $past(CHIP_SELECT_N, 1) && !$past(CHIP_SELECT_N, 2))
    else $error("configuration changed outside a frame end");
  chk_tx_quiet: assert property (!TX_ACTIVE |-> !TX_BIT)
    else $error("antenna bit high while idle");
  // The first bit holds one extra cycle while the registered bit pulse of
  // the divider fills, so a full run is one cycle over the plain product.
  chk_tx_length: assert property ($fell(TX_ACTIVE) && !OUTPUTS_TRISTATE |->
    act_cnt == 2 * DATA_BITS * TX_BIT_CYCLES + 1)
    else $error("transmission length wrong");
  chk_no_tx_asleep: assert property (s_asleep |-> !TX_ACTIVE)
    else $error("transmission while asleep");
endmodule
bind lfd_cmd_top lfd_cmd_properties #(.TX_BIT_CYCLES(TX_BIT_CYCLES)) i_chk (.*);
`default_nettype wire

/* File: verif/lfd_host_model.sv */
// Host controller model that sends serial frames to the driver.
`timescale 1ns/10ps
`default_nettype none
module lfd_host_model
(
  input  wire logic MCLK,          // System clock.
  output logic      SCLK,          // Serial clock, idles low.
  output logic      SDI,           // Serial data to the device.
  output logic      CHIP_SELECT_N, // Frame select, active low.
  input  wire logic SDO            // Serial data from the device.
);
  // Idle bus: clock low and no frame selected.
  initial
  begin
    SCLK = 1'b0;
    SDI = 1'b0;
    CHIP_SELECT_N = 1'b1;
  end
  // Sends n bits MSB first; each phase lasts over two clocks so the device sees it.
  task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = '0;
    @(negedge MCLK);
    CHIP_SELECT_N = 1'b0;
    for (int i = 63; i > 63 - n; i--)
    begin
      SDI = tx[i];
      repeat (3) @(negedge MCLK);
      rx[i] = SDO;
      SCLK = 1'b1;
      repeat (3) @(negedge MCLK);
      SCLK = 1'b0;
    end
    repeat (3) @(negedge MCLK);
    CHIP_SELECT_N = 1'b1;
    // A released line must not keep looking like valid data.
    SDI = ~SDI;
    repeat (3) @(negedge MCLK);
  endtask
endmodule
`default_nettype wire

/* File: verif/lfd_cmd_top_test.sv */
// Self-checking bench for the command interpreter top.
`timescale 1ns/10ps
`default_nettype none
module lfd_cmd_top_test;
  import lfd_pkg::*;
  localparam int unsigned TBC = 16; // Short bit time keeps the run brief.
  localparam logic [55:0] P1 = 56'hC3A5_5A0F_F012_34;
  localparam logic [55:0] P2 = 56'h81_7E00_FF55_AA33;
  localparam logic [55:0] ALL1 = 56'hFF_FFFF_FFFF_FFFF;
  logic MCLK, RST_N, SCLK, SDI, CHIP_SELECT_N, SDO, SDO_OE, TX_BIT, TX_ACTIVE;
  logic PREWARN_IN, OVERTEMP_IN, VD_LOW_IN, VS_LOW_IN, MEAS_A_VALID, MEAS_B_VALID;
  logic OUTPUTS_TRISTATE, MEAS_REARM;
  logic [7:0]   OVERCURRENT_IN; // Overcurrent events.
  logic [4:0]   MEAS_A_VALUE;   // First current.
  logic [4:0]   MEAS_B_VALUE;   // Second current.
  logic [55:0]  CONFIG_WORD;    // Configuration register.
  logic [27:0]  MEAS_SETUP;     // Measurement setup.
  logic [63:0]  rx;             // Word returned by the last frame.
  logic [111:0] bits;           // Captured antenna bits.
  int n_mismatch = 0;
  int n_tests = 0;
  // Each row: frame sent, then word expected back in the same frame.
  logic [127:0] rows [11] = '{
    {8'h10, 56'h0, 8'h00, CFG_RESET}, // Wake-up frame stands alone.
    {8'h90, 56'h0, 8'h10, 56'h0},
    {8'h30, P1, 8'h90, 56'h0},
    {8'h40, P2, 8'h30, P1},
    {8'h00, 56'h0, 8'h40, P2},
    {8'h80, 56'h0, 8'h00, 56'h0},
    {8'hA0, ALL1, 8'h80, MEAS_RESET, 28'h0},
    {8'h00, 56'h0, 8'hA0, 28'hFFFFFFF, 28'h0},
    {8'h60, ALL1, 8'h00, 56'h0},
    {8'h70, ALL1, 8'h60, 56'h0},
    {8'h00, 56'h0, 8'h70, 56'h0}
  };
  lfd_cmd_top #(.TX_BIT_CYCLES(TBC)) i_dut (.*);
  lfd_host_model i_host (.*);
  // Status word after the all-ones setup write, with the currents used here.
  function automatic logic [55:0] st(logic [1:0] mode, logic [4:0] fl, logic [7:0] oc);
    return {28'hFFFFFFF, 2'h0, mode, 1'b0, fl, oc, 5'h15, 5'h0A};
  endfunction
  // Compares with case equality so an unknown never matches.
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // The single place where the run ends.
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Free-running clock at 125 MHz.
  initial
  begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end
  // A hang counts as a failure.
  initial
  begin
    repeat (40000) @(posedge MCLK);
    n_mismatch++;
    report_and_stop();
  end
  // Main sequence: reset, table of frames, then the awkward cases.
  initial
  begin
    RST_N = 1'b0;
    {PREWARN_IN, OVERTEMP_IN, VD_LOW_IN, VS_LOW_IN, MEAS_A_VALID, MEAS_B_VALID} = '0;
    OVERCURRENT_IN = 8'h00;
    MEAS_A_VALUE = 5'h15;
    MEAS_B_VALUE = 5'h0A;
    repeat (10) @(negedge MCLK);
    RST_N = 1'b1;
    repeat (2) @(negedge MCLK);
    chk(CONFIG_WORD, CFG_RESET);
    chk(MEAS_SETUP, MEAS_RESET);
    chk({OUTPUTS_TRISTATE, TX_ACTIVE}, 2'h2);
    foreach (rows[i])
    begin
      i_host.xfer(rows[i][127:64], 64, rx);
      chk(rx, rows[i][63:0]);
    end
    chk(MEAS_SETUP, 28'hFFFFFFF);
    // Events arrive after a config readback so nothing reads them early.
    i_host.xfer({8'h80, 56'h0}, 64, rx);
    {PREWARN_IN, OVERTEMP_IN, VD_LOW_IN, VS_LOW_IN, MEAS_A_VALID, MEAS_B_VALID} = 6'h3F;
    OVERCURRENT_IN = 8'h05;
    @(negedge MCLK);
    {PREWARN_IN, OVERTEMP_IN, VD_LOW_IN, VS_LOW_IN, MEAS_A_VALID, MEAS_B_VALID} = '0;
    OVERCURRENT_IN = 8'h00;
    i_host.xfer({8'h80, 56'h0}, 64, rx);
    chk(rx, {8'h80, st(2'h0, 5'h1F, 8'h05)});
    i_host.xfer({8'h00, 56'h0}, 64, rx);
    chk(rx, {8'h80, st(2'h0, 5'h00, 8'h00)});
    // A short frame must leave the configuration alone.
    i_host.xfer({8'h10, 56'h1}, 40, rx);
    chk(CONFIG_WORD, 56'h0);
    repeat (8000) @(negedge MCLK);
    i_host.xfer({8'hD0, 56'h0}, 64, rx);
    chk(TX_ACTIVE, 1'b1);
    fork
      begin
        repeat (TBC / 2) @(negedge MCLK);
        for (int i = 111; i >= 0; i--)
        begin
          bits[i] = TX_BIT;
          repeat (TBC) @(negedge MCLK);
        end
      end
      begin
        i_host.xfer({8'h80, 56'h0}, 64, rx);
        chk(rx, {8'hD0, st(2'h2, 5'h0, 8'h0)});
        repeat (700) @(negedge MCLK);
        i_host.xfer({8'h80, 56'h0}, 64, rx);
        chk(rx, {8'h80, st(2'h3, 5'h0, 8'h0)});
      end
    join
    chk(bits, {P1, P2});
    chk(TX_ACTIVE, 1'b0);
    // Send mode 1 starts on the data1 write; sleep then aborts it.
    i_host.xfer({8'h10, 56'h2}, 64, rx);
    i_host.xfer({8'h30, P2}, 64, rx);
    chk(TX_ACTIVE, 1'b1);
    i_host.xfer({8'h10, 56'h3}, 64, rx);
    chk({OUTPUTS_TRISTATE, TX_ACTIVE}, 2'h2);
    i_host.xfer({8'hD0, 56'h0}, 64, rx);
    chk(TX_ACTIVE, 1'b0);
    i_host.xfer({8'h10, 56'h0}, 64, rx);
    chk({OUTPUTS_TRISTATE, MEAS_SETUP}, {1'b0, 28'hFFFFFFF});
    report_and_stop();
  end
endmodule
`default_nettype wire
